// file: src/usm_pkg.sv
/*
 * Shared constants for the synchronous-master / single-wire serial block:
 * register offsets, control bit positions, reset values, frame counts, states.
 * Assumes a byte-addressed register port with 32-bit data words.
 */
package usm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BAUD_W = 16;
	localparam int CHAR_W = 8;
	localparam int CFG_W  = BAUD_W + 8;

	localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CTRL3 = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_BAUD  = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_REQ   = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h1c;
	localparam logic [ADDR_W-1:0] ADDR_RXD   = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_TXD   = 8'h28;

	localparam int PE_BIT    = 0;
	localparam int RE_BIT    = 2;
	localparam int TE_BIT    = 3;
	localparam int LAST_BIT_CLOCK_PULSE_BIT  = 8;
	localparam int CLOCK_PHASE_SELECT_BIT  = 9;
	localparam int CLOCK_POLARITY_SELECT_BIT  = 10;
	localparam int SYNC_BIT  = 11;
	localparam int LIN_BIT   = 14;
	localparam int IR_BIT    = 1;
	localparam int HD_BIT    = 3;
	localparam int SC_BIT    = 5;
	localparam int BRK_BIT   = 1;
	localparam int ST_RXNE   = 5;
	localparam int ST_TXE    = 7;
	localparam int ST_BUSY   = 16;

	localparam logic [DATA_W-1:0] CTRL1_MASK = 32'h0000_000d;
	localparam logic [DATA_W-1:0] CTRL2_MASK = 32'h0000_4f00;
	localparam logic [DATA_W-1:0] CTRL3_MASK = 32'h0000_002a;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0010;
	localparam logic [BAUD_W-1:0] BAUD_MIN   = 16'h0002;
	localparam logic [BAUD_W-1:0] BAUD_ONE   = 16'h0001;

	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] FRAME_LAST    = 4'h9;
	localparam logic [3:0] BREAK_LAST    = 4'h9;

	typedef enum logic [2:0] {TxIdle, TxPreamble, TxStart, TxData, TxStop, TxBreak} usm_tx_state_t;
	typedef enum logic [1:0] {RxIdle, RxStart, RxData, RxStop} usm_rx_state_t;
endpackage

// file: src/usm_serial_core.sv
/*
 * Serial transceiver core with synchronous master clock output and
 * single-wire half-duplex mode. Registers live on sys_clk; the bit engine
 * runs on linkClk (kernel/baud clock). Assumes the far side keeps to the
 * mode exclusivity rules and reprograms clock settings only while disabled.
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module usm_serial_core (
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic [usm_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [usm_pkg::DATA_W-1:0] regWdata,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	output logic      [usm_pkg::DATA_W-1:0] regRdata,
	input  wire logic                       linkClk,
	input  wire logic                       txPinIn,
	output logic                            txPinOut,
	output logic                            txPinOe,
	input  wire logic                       rxPin,
	output logic                            syncClockOut
);
	// ----------------------------------------------------------------
	// register side (sys_clk)
	// ----------------------------------------------------------------
	logic [usm_pkg::DATA_W-1:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
	logic [usm_pkg::DATA_W-1:0] ctrl3_reg, ctrl3_next, rdata_reg, rdata_next;
	logic [usm_pkg::BAUD_W-1:0] baud_reg, baud_next;
	logic [usm_pkg::CHAR_W-1:0] txData_reg, txData_next, rdr_reg, rdr_next;
	logic                       txBrk_reg, txBrk_next, txReq_reg, txReq_next;
	logic                       rxValid_reg, rxValid_next;
	logic                       ackS1_reg, ackS2_reg, busyS1_reg, busyS2_reg;
	logic                       rxS1_reg, rxS2_reg, rxS3_reg;
	logic                       txPending, rxHit;
	logic [usm_pkg::DATA_W-1:0] status;
	logic [usm_pkg::CFG_W-1:0]  cfgSys;
	// link-side values read across
	logic [usm_pkg::CHAR_W-1:0] rxWord_reg;
	logic                       ackTog_reg, rxTog_reg, busy_reg;

	assign txPending = txReq_reg != ackS2_reg;
	assign rxHit     = rxS2_reg ^ rxS3_reg;
	assign regRdata  = rdata_reg;
	assign cfgSys    = {baud_reg, ctrl1_reg[usm_pkg::PE_BIT], ctrl1_reg[usm_pkg::TE_BIT],
		ctrl1_reg[usm_pkg::RE_BIT], ctrl2_reg[usm_pkg::SYNC_BIT], ctrl2_reg[usm_pkg::CLOCK_POLARITY_SELECT_BIT],
		ctrl2_reg[usm_pkg::CLOCK_PHASE_SELECT_BIT], ctrl2_reg[usm_pkg::LAST_BIT_CLOCK_PULSE_BIT], ctrl3_reg[usm_pkg::HD_BIT]};

	always_comb begin
		status = '0;
		status[usm_pkg::ST_RXNE] = rxValid_reg;
		status[usm_pkg::ST_TXE]  = !txPending;
		status[usm_pkg::ST_BUSY] = busyS2_reg;
	end

	always_comb begin
		ctrl1_next   = ctrl1_reg;
		ctrl2_next   = ctrl2_reg;
		ctrl3_next   = ctrl3_reg;
		baud_next    = baud_reg;
		txData_next  = txData_reg;
		txBrk_next   = txBrk_reg;
		txReq_next   = txReq_reg;
		rxValid_next = rxValid_reg;
		rdr_next     = rdr_reg;
		rdata_next   = '0;
		if (regWr) begin
			case (regAddr)
				usm_pkg::ADDR_CTRL1: ctrl1_next = regWdata & usm_pkg::CTRL1_MASK;
				usm_pkg::ADDR_CTRL2: ctrl2_next = regWdata & usm_pkg::CTRL2_MASK;
				usm_pkg::ADDR_CTRL3: ctrl3_next = regWdata & usm_pkg::CTRL3_MASK;
				usm_pkg::ADDR_BAUD: begin
					// divisor below two leaves no half-bit point for the clock
					baud_next = (regWdata[usm_pkg::BAUD_W-1:0] < usm_pkg::BAUD_MIN) ?
						usm_pkg::BAUD_MIN : regWdata[usm_pkg::BAUD_W-1:0];
				end
				usm_pkg::ADDR_TXD: begin
					if (!txPending) begin
						txData_next = regWdata[usm_pkg::CHAR_W-1:0];
						txBrk_next  = 1'b0;
						txReq_next  = !txReq_reg;
					end
				end
				usm_pkg::ADDR_REQ: begin
					if (!txPending && regWdata[usm_pkg::BRK_BIT]) begin
						txBrk_next = 1'b1;
						txReq_next = !txReq_reg;
					end
				end
				default: ;
			endcase
		end
		if (regRd && regAddr == usm_pkg::ADDR_RXD)
			rxValid_next = 1'b0;
		// a word arriving on the read that clears the flag is kept
		if (rxHit) begin
			rxValid_next = 1'b1;
			rdr_next     = rxWord_reg;
		end
		if (regRd) begin
			case (regAddr)
				usm_pkg::ADDR_CTRL1: rdata_next = ctrl1_reg;
				usm_pkg::ADDR_CTRL2: rdata_next = ctrl2_reg;
				usm_pkg::ADDR_CTRL3: rdata_next = ctrl3_reg;
				usm_pkg::ADDR_BAUD:  rdata_next = {{(usm_pkg::DATA_W-usm_pkg::BAUD_W){1'b0}}, baud_reg};
				usm_pkg::ADDR_STAT:  rdata_next = status;
				usm_pkg::ADDR_RXD:   rdata_next = {{(usm_pkg::DATA_W-usm_pkg::CHAR_W){1'b0}}, rdr_reg};
				default:             rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl1_reg   <= usm_pkg::CTRL_RESET;
			ctrl2_reg   <= usm_pkg::CTRL_RESET;
			ctrl3_reg   <= usm_pkg::CTRL_RESET;
			baud_reg    <= usm_pkg::BAUD_RESET;
			txData_reg  <= '0;
			txBrk_reg   <= 1'b0;
			txReq_reg   <= 1'b0;
			rxValid_reg <= 1'b0;
			rdr_reg     <= '0;
			rdata_reg   <= '0;
			ackS1_reg   <= 1'b0;
			ackS2_reg   <= 1'b0;
			busyS1_reg  <= 1'b0;
			busyS2_reg  <= 1'b0;
			rxS1_reg    <= 1'b0;
			rxS2_reg    <= 1'b0;
			rxS3_reg    <= 1'b0;
		end else begin
			ctrl1_reg   <= ctrl1_next;
			ctrl2_reg   <= ctrl2_next;
			ctrl3_reg   <= ctrl3_next;
			baud_reg    <= baud_next;
			txData_reg  <= txData_next;
			txBrk_reg   <= txBrk_next;
			txReq_reg   <= txReq_next;
			rxValid_reg <= rxValid_next;
			rdr_reg     <= rdr_next;
			rdata_reg   <= rdata_next;
			ackS1_reg   <= ackTog_reg;
			ackS2_reg   <= ackS1_reg;
			busyS1_reg  <= busy_reg;
			busyS2_reg  <= busyS1_reg;
			rxS1_reg    <= rxTog_reg;
			rxS2_reg    <= rxS1_reg;
			rxS3_reg    <= rxS2_reg;
		end
	end

	sequence s_txdWrite;
		regWr && regAddr == usm_pkg::ADDR_TXD && !txPending;
	endsequence
	property p_TxAccepted;
		@(posedge sys_clk) disable iff (!rstn)
		s_txdWrite |=> txPending && txData_reg == $past(regWdata[usm_pkg::CHAR_W-1:0]);
	endproperty
	a_TxAccepted: assert property (p_TxAccepted) else $error("data write not taken");

	// ----------------------------------------------------------------
	// link side (linkClk)
	// ----------------------------------------------------------------
	usm_pkg::usm_tx_state_t txState_reg, txState_next;
	usm_pkg::usm_rx_state_t rxState_reg, rxState_next;
	logic                       lrst1_reg, linkRstn;
	logic [usm_pkg::CFG_W-1:0]  cfgS1_reg, cfgS2_reg;
	logic [usm_pkg::BAUD_W-1:0] cBaud, half, baudCnt_reg, baudCnt_next, rxCnt_reg, rxCnt_next;
	logic                       cPe, cTe, cRe, cSync, cCpol, cCpha, cLbcl, cHd;
	logic                       reqS1_reg, reqS2_reg, txInS1_reg, txInS2_reg, rxInS1_reg, rxInS2_reg;
	logic [3:0]                 bitCnt_reg, bitCnt_next, rxBits_reg, rxBits_next;
	logic [usm_pkg::CHAR_W-1:0] txShift_reg, txShift_next, rxShift_reg, rxShift_next;
	logic [usm_pkg::CHAR_W-1:0] rxWord_next, rxWord_q;
	logic                       txLevel_reg, txLevel_next, sck_reg, sck_next;
	logic                       txOut_reg, txOut_next, txOe_reg, txOe_next;
	logic                       teSeen_reg, ackTog_next, rxTog_next;
	logic                       bitTick, midTick, pulseOn, reqPending, acceptTx, rxEn;
	logic                       rxLine, rxSample, rxDeliver, linkOn;

	// settings are quasi-static: only changed while the block is disabled
	assign {cBaud, cPe, cTe, cRe, cSync, cCpol, cCpha, cLbcl, cHd} = cfgS2_reg;
	assign half       = cBaud >> 1;
	assign bitTick    = baudCnt_reg == cBaud - usm_pkg::BAUD_ONE;
	assign midTick    = baudCnt_reg == half - usm_pkg::BAUD_ONE;
	assign linkOn     = cPe && cTe;
	assign reqPending = reqS2_reg != ackTog_reg;
	assign acceptTx   = txState_reg == usm_pkg::TxIdle && linkOn && teSeen_reg && reqPending;
	assign rxEn       = cPe && cRe;
	// half duplex: own line loops back; the receive pin is ignored
	assign rxLine     = cHd ? txInS2_reg : rxInS2_reg;
	assign pulseOn    = cSync && txState_reg == usm_pkg::TxData &&
		(bitCnt_reg != usm_pkg::LAST_DATA_BIT || cLbcl);
	assign txPinOut   = txOut_reg;
	assign txPinOe    = txOe_reg;
	assign syncClockOut = sck_reg;
	assign busy_reg   = txState_reg != usm_pkg::TxIdle;
	assign rxWord_reg = rxWord_q;

	always_comb begin
		txState_next = txState_reg;
		baudCnt_next = bitTick ? '0 : baudCnt_reg + usm_pkg::BAUD_ONE;
		bitCnt_next  = bitCnt_reg;
		txShift_next = txShift_reg;
		txLevel_next = txLevel_reg;
		ackTog_next  = ackTog_reg;
		if (!linkOn) begin
			txState_next = usm_pkg::TxIdle;
			txLevel_next = 1'b1;
			baudCnt_next = '0;
		end else if (txState_reg == usm_pkg::TxIdle) begin
			baudCnt_next = '0;
			bitCnt_next  = '0;
			if (!teSeen_reg) begin
				txState_next = usm_pkg::TxPreamble;
			end else if (acceptTx) begin
				// taken at once; half duplex never holds off a send
				ackTog_next  = !ackTog_reg;
				txShift_next = txData_reg;
				txLevel_next = 1'b0;
				txState_next = txBrk_reg ? usm_pkg::TxBreak : usm_pkg::TxStart;
			end
		end else if (bitTick) begin
			case (txState_reg)
				usm_pkg::TxPreamble: begin
					bitCnt_next = bitCnt_reg + 4'h1;
					if (bitCnt_reg == usm_pkg::FRAME_LAST)
						txState_next = usm_pkg::TxIdle;
				end
				usm_pkg::TxStart: begin
					// same framing as async; only the clock is added
					txState_next = usm_pkg::TxData;
					bitCnt_next  = '0;
					txLevel_next = txShift_reg[0];
				end
				usm_pkg::TxData: begin
					if (bitCnt_reg == usm_pkg::LAST_DATA_BIT) begin
						txState_next = usm_pkg::TxStop;
						txLevel_next = 1'b1;
					end else begin
						bitCnt_next  = bitCnt_reg + 4'h1;
						txShift_next = txShift_reg >> 1;
						txLevel_next = txShift_reg[1];
					end
				end
				usm_pkg::TxBreak: begin
					bitCnt_next = bitCnt_reg + 4'h1;
					if (bitCnt_reg == usm_pkg::BREAK_LAST) begin
						txState_next = usm_pkg::TxStop;
						txLevel_next = 1'b1;
					end
				end
				usm_pkg::TxStop: txState_next = usm_pkg::TxIdle;
				default:         txState_next = usm_pkg::TxIdle;
			endcase
		end
		// leading half idle for phase 0, active for phase 1
		if (!cSync)
			sck_next = 1'b0;
		else if (pulseOn)
			sck_next = cCpol ^ (cCpha ? (baudCnt_reg < half) : (baudCnt_reg >= half));
		else
			sck_next = cCpol;
		// open drain in half duplex: only a low is driven
		txOut_next = cHd ? 1'b0 : txLevel_reg;
		txOe_next  = cHd ? !txLevel_reg : cPe;
	end

	always_comb begin
		rxState_next = rxState_reg;
		rxCnt_next   = rxCnt_reg + usm_pkg::BAUD_ONE;
		rxBits_next  = rxBits_reg;
		rxShift_next = rxShift_reg;
		rxSample     = 1'b0;
		rxDeliver    = 1'b0;
		if (!rxEn) begin
			rxState_next = usm_pkg::RxIdle;
			rxCnt_next   = '0;
		end else if (cSync) begin
			// no oversampling: one look per bit at the capture edge
			rxState_next = usm_pkg::RxIdle;
			rxCnt_next   = '0;
			if (txState_reg == usm_pkg::TxData && midTick) begin
				rxSample     = 1'b1;
				rxShift_next = {rxLine, rxShift_reg[usm_pkg::CHAR_W-1:1]};
				rxDeliver    = bitCnt_reg == usm_pkg::LAST_DATA_BIT;
			end
		end else begin
			case (rxState_reg)
				usm_pkg::RxIdle: begin
					rxCnt_next = '0;
					if (!rxLine)
						rxState_next = usm_pkg::RxStart;
				end
				usm_pkg::RxStart: begin
					if (rxCnt_reg == half - usm_pkg::BAUD_ONE) begin
						rxCnt_next   = '0;
						rxBits_next  = '0;
						rxState_next = rxLine ? usm_pkg::RxIdle : usm_pkg::RxData;
					end
				end
				usm_pkg::RxData: begin
					if (rxCnt_reg == cBaud - usm_pkg::BAUD_ONE) begin
						rxCnt_next   = '0;
						rxSample     = 1'b1;
						rxShift_next = {rxLine, rxShift_reg[usm_pkg::CHAR_W-1:1]};
						rxBits_next  = rxBits_reg + 4'h1;
						if (rxBits_reg == usm_pkg::LAST_DATA_BIT)
							rxState_next = usm_pkg::RxStop;
					end
				end
				usm_pkg::RxStop: begin
					if (rxCnt_reg == cBaud - usm_pkg::BAUD_ONE) begin
						// a low stop bit is a framing fault: word dropped
						rxDeliver    = rxLine;
						rxState_next = usm_pkg::RxIdle;
					end
				end
				default: rxState_next = usm_pkg::RxIdle;
			endcase
		end
		rxTog_next  = rxDeliver ? !rxTog_reg : rxTog_reg;
		rxWord_next = rxDeliver ? rxShift_next : rxWord_q;
	end

	always_ff @(posedge linkClk or negedge rstn) begin
		if (!rstn) begin
			lrst1_reg <= 1'b0;
			linkRstn  <= 1'b0;
		end else begin
			lrst1_reg <= 1'b1;
			linkRstn  <= lrst1_reg;
		end
	end

	always_ff @(posedge linkClk or negedge linkRstn) begin
		if (!linkRstn) begin
			cfgS1_reg   <= '0;
			cfgS2_reg   <= {usm_pkg::BAUD_RESET, {(usm_pkg::CFG_W-usm_pkg::BAUD_W){1'b0}}};
			reqS1_reg   <= 1'b0;
			reqS2_reg   <= 1'b0;
			txInS1_reg  <= 1'b1;
			txInS2_reg  <= 1'b1;
			rxInS1_reg  <= 1'b1;
			rxInS2_reg  <= 1'b1;
			txState_reg <= usm_pkg::TxIdle;
			rxState_reg <= usm_pkg::RxIdle;
			baudCnt_reg <= '0;
			rxCnt_reg   <= '0;
			bitCnt_reg  <= '0;
			rxBits_reg  <= '0;
			txShift_reg <= '0;
			rxShift_reg <= '0;
			rxWord_q    <= '0;
			txLevel_reg <= 1'b1;
			sck_reg     <= 1'b0;
			txOut_reg   <= 1'b1;
			txOe_reg    <= 1'b0;
			teSeen_reg  <= 1'b0;
			ackTog_reg  <= 1'b0;
			rxTog_reg   <= 1'b0;
		end else begin
			cfgS1_reg   <= cfgSys;
			cfgS2_reg   <= cfgS1_reg;
			reqS1_reg   <= txReq_reg;
			reqS2_reg   <= reqS1_reg;
			txInS1_reg  <= txPinIn;
			txInS2_reg  <= txInS1_reg;
			rxInS1_reg  <= rxPin;
			rxInS2_reg  <= rxInS1_reg;
			txState_reg <= txState_next;
			rxState_reg <= rxState_next;
			baudCnt_reg <= baudCnt_next;
			rxCnt_reg   <= rxCnt_next;
			bitCnt_reg  <= bitCnt_next;
			rxBits_reg  <= rxBits_next;
			txShift_reg <= txShift_next;
			rxShift_reg <= rxShift_next;
			rxWord_q    <= rxWord_next;
			txLevel_reg <= txLevel_next;
			sck_reg     <= sck_next;
			txOut_reg   <= txOut_next;
			txOe_reg    <= txOe_next;
			teSeen_reg  <= linkOn;
			ackTog_reg  <= ackTog_next;
			rxTog_reg   <= rxTog_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_quietSlot;
		cSync && !pulseOn;
	endsequence
	sequence s_lastBitNoPulse;
		cSync && txState_reg == usm_pkg::TxData && bitCnt_reg == usm_pkg::LAST_DATA_BIT && !cLbcl;
	endsequence

	property p_SyncOffLow;
		@(posedge linkClk) disable iff (!linkRstn) !cSync |=> !syncClockOut;
	endproperty
	a_SyncOffLow: assert property (p_SyncOffLow) else $error("clock out active with sync off");

	property p_QuietOutsideData;
		@(posedge linkClk) disable iff (!linkRstn)
		(cSync && txState_reg != usm_pkg::TxData) |=> syncClockOut == $past(cCpol);
	endproperty
	a_QuietOutsideData: assert property (p_QuietOutsideData) else $error("pulse outside data");

	property p_LastBit;
		@(posedge linkClk) disable iff (!linkRstn)
		s_lastBitNoPulse ##1 s_lastBitNoPulse |-> syncClockOut == cCpol;
	endproperty
	a_LastBit: assert property (p_LastBit) else $error("last bit pulse not suppressed");

	property p_PolPhase;
		@(posedge linkClk) disable iff (!linkRstn)
		(pulseOn && baudCnt_reg == '0) |=> syncClockOut == ($past(cCpol) ^ $past(cCpha));
	endproperty
	a_PolPhase: assert property (p_PolPhase) else $error("wrong level at bit start");

	property p_RestLevel;
		@(posedge linkClk) disable iff (!linkRstn)
		s_quietSlot ##1 s_quietSlot |-> syncClockOut == $past(cCpol);
	endproperty
	a_RestLevel: assert property (p_RestLevel) else $error("clock not at rest level");

	property p_FrameShape;
		@(posedge linkClk) disable iff (!linkRstn)
		(acceptTx && !txBrk_reg) |=> txState_reg == usm_pkg::TxStart ##1 !txOut_reg || cHd;
	endproperty
	a_FrameShape: assert property (p_FrameShape) else $error("start bit not low");

	property p_SyncSample;
		@(posedge linkClk) disable iff (!linkRstn)
		(rxSample && cSync) |-> txState_reg == usm_pkg::TxData && baudCnt_reg == half - usm_pkg::BAUD_ONE;
	endproperty
	a_SyncSample: assert property (p_SyncSample) else $error("sync sample off the edge");

	property p_ClockNeedsTx;
		@(posedge linkClk) disable iff (!linkRstn)
		// a new setting moves the output one cycle late; the return to rest
		// after a live last bit lands one cycle after leaving the data state
		($changed(syncClockOut) && $stable(cfgS2_reg) && cfgS2_reg == $past(cfgS2_reg, 2)) |->
			($past(txState_reg) == usm_pkg::TxData || $past(txState_reg, 2) == usm_pkg::TxData);
	endproperty
	a_ClockNeedsTx: assert property (p_ClockNeedsTx) else $error("clock moved without a frame");

	property p_HdRelease;
		@(posedge linkClk) disable iff (!linkRstn)
		(cHd && txState_reg == usm_pkg::TxIdle && txLevel_reg) |=> !txPinOe && !txPinOut;
	endproperty
	a_HdRelease: assert property (p_HdRelease) else $error("line held while idle");

	property p_RxGated;
		@(posedge linkClk) disable iff (!linkRstn) !rxEn |=> $stable(rxTog_reg);
	endproperty
	a_RxGated: assert property (p_RxGated) else $error("word received while disabled");
endmodule

// file: tb/usm_line_model.sv
/*
 * Far side of the serial block: a synchronous slave that samples tx on the
 * master clock and answers on rx, plus the shared open-drain wire.
 * Assumes the bench sets baud, sampling level and answer byte beforehand.
 */
`timescale 1ns/1ps
module usm_line_model (
	input  wire logic linkClk,
	input  wire logic txPinOut,
	input  wire logic txPinOe,
	input  wire logic syncClockOut,
	output logic      txWire,
	output logic      rxLine
);
	logic       pullLow   = 1'b0;
	logic       rxLvl     = 1'b1;
	logic       rxJam     = 1'b0;
	logic       respond   = 1'b0;
	logic       sampleLvl = 1'b1;
	logic       clkPrev   = 1'b0;
	logic [7:0] respByte  = 8'h00;
	logic [7:0] capByte   = 8'h00;
	int         pulses    = 0;
	int         baud      = 8;

	// pull-up wire: whoever pulls low wins
	assign txWire = ((txPinOe && !txPinOut) || pullLow) ? 1'b0 : 1'b1;
	assign rxLine = rxJam ? 1'b0 : rxLvl;

	// slave samples tx on the mid-bit edge given by polarity and phase
	always @(posedge linkClk) begin
		if (syncClockOut !== clkPrev && syncClockOut === sampleLvl) begin
			capByte <= {txPinOut, capByte[7:1]};
			pulses  <= pulses + 1;
		end
		clkPrev <= syncClockOut;
	end

	task automatic drive_bit(input logic b, input logic onWire);
		if (onWire)
			pullLow <= !b;
		else
			rxLvl <= b;
		repeat (baud) @(posedge linkClk);
	endtask

	// another party on the shared wire, lsb first
	task automatic send_frame(input logic [7:0] d, input logic onWire);
		drive_bit(1'b0, onWire);
		for (int i = 0; i < 8; i++)
			drive_bit(d[i], onWire);
		drive_bit(1'b1, onWire);
	endtask

	// answer only alongside a master frame; half a bit early for setup
	initial forever begin
		@(negedge txPinOut);
		if (respond) begin
			repeat (baud / 2) @(posedge linkClk);
			for (int i = 0; i < 8; i++)
				drive_bit(respByte[i], 1'b0);
			rxLvl <= 1'b1;
		end
	end
endmodule

// file: tb/usm_serial_core_tb_top.sv
/*
 * Self-checking bench for the serial core: register tasks, sync master
 * frames in all four polarity and phase settings, break, and single-wire half duplex.
 * Assumes the line model above sits on the pins.
 */
`timescale 1ns/1ps
module usm_serial_core_tb_top;
	logic        sys_clk  = 1'b0;
	logic        linkClk  = 1'b0;
	logic        rstn     = 1'b0;
	logic [7:0]  regAddr  = 8'h00;
	logic [31:0] regWdata = 32'h0;
	logic        regWr    = 1'b0;
	logic        regRd    = 1'b0;
	logic [31:0] regRdata;
	logic        txPinOut;
	logic        txPinOe;
	logic        syncClockOut;
	logic        txWire;
	logic        rxLine;
	logic [31:0] rd;
	logic        pol;
	logic        pha;
	logic        lb;
	logic [7:0]  d;
	int          n_errors    = 0;
	int          checks_done = 0;

	initial forever #5 sys_clk = ~sys_clk;
	// unrelated phase to sys_clk
	initial begin
		#3.7;
		forever #6 linkClk = ~linkClk;
	end

	usm_serial_core dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.linkClk(linkClk), .txPinIn(txWire), .txPinOut(txPinOut), .txPinOe(txPinOe),
		.rxPin(rxLine), .syncClockOut(syncClockOut));
	usm_line_model model (.linkClk(linkClk), .txPinOut(txPinOut), .txPinOe(txPinOe),
		.syncClockOut(syncClockOut), .txWire(txWire), .rxLine(rxLine));

	// ----------------------------------------
	// register access and comparison
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= v;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask

	task automatic rdreg(input logic [7:0] a);
		@(posedge sys_clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		rdreg(a);
		chk(rd, exp);
	endtask

	// bounded poll: transmitter seen busy, then idle with data register empty
	task automatic wait_idle();
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 1000; i++) begin
			rdreg(usm_pkg::ADDR_STAT);
			if (rd[usm_pkg::ST_BUSY] === 1'b1)
				seen = 1'b1;
			else if (seen && rd[usm_pkg::ST_TXE] === 1'b1)
				return;
		end
		chk(32'h1, 32'h0);
	endtask

	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#200us;
		n_errors++;
		results();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({30'h0, txPinOe, syncClockOut}, 32'h0);
		chk_reg(usm_pkg::ADDR_CTRL2, 32'h0);
		chk_reg(usm_pkg::ADDR_BAUD, 32'h10);
		chk_reg(usm_pkg::ADDR_STAT, 32'h80);
		chk_reg(8'h40, 32'h0);
		wr(usm_pkg::ADDR_BAUD, 32'h8);
		for (int m = 0; m < 4; m++) begin
			pol = m[1];
			pha = m[0];
			lb  = m[0] ^ m[1];
			d   = 8'hb4 ^ 8'(m * 37);
			wr(usm_pkg::ADDR_CTRL1, 32'h0);
			wr(usm_pkg::ADDR_CTRL2, 32'h800 | {21'h0, pol, pha, lb, 8'h00});
			model.sampleLvl = pol ^ ~pha;
			model.respond   = 1'b1;
			model.respByte  = ~d;
			repeat (10) @(posedge sys_clk);
			chk({31'h0, syncClockOut}, {31'h0, pol});
			model.pulses = 0;
			wr(usm_pkg::ADDR_CTRL1, 32'hd);
			wr(usm_pkg::ADDR_TXD, {24'h0, d});
			wait_idle();
			chk(32'(model.pulses), lb ? 32'h8 : 32'h7);
			chk({24'h0, lb ? model.capByte : {1'b0, model.capByte[7:1]}},
				{24'h0, lb ? d : {1'b0, d[6:0]}});
			chk_reg(usm_pkg::ADDR_STAT, 32'ha0);
			chk_reg(usm_pkg::ADDR_RXD, {24'h0, ~d});
			model.pulses = 0;
			wr(usm_pkg::ADDR_REQ, 32'h2);
			wait_idle();
			chk(32'(model.pulses), 32'h0);
			chk({31'h0, syncClockOut}, {31'h0, pol});
		end
		// single wire: rx pin held low must not matter
		wr(usm_pkg::ADDR_CTRL1, 32'h0);
		wr(usm_pkg::ADDR_CTRL2, 32'h0);
		wr(usm_pkg::ADDR_CTRL3, 32'h8);
		model.respond = 1'b0;
		model.rxJam   = 1'b1;
		wr(usm_pkg::ADDR_CTRL1, 32'hd);
		repeat (10) @(posedge sys_clk);
		chk({30'h0, txPinOe, txPinOut}, 32'h0);
		wr(usm_pkg::ADDR_TXD, 32'h3c);
		wait_idle();
		chk_reg(usm_pkg::ADDR_STAT, 32'ha0);
		chk_reg(usm_pkg::ADDR_RXD, 32'h3c);
		model.send_frame(8'ha5, 1'b1);
		repeat (10) @(posedge sys_clk);
		chk_reg(usm_pkg::ADDR_RXD, 32'ha5);
		wr(usm_pkg::ADDR_CTRL1, 32'h9);
		model.send_frame(8'h5a, 1'b1);
		repeat (10) @(posedge sys_clk);
		chk_reg(usm_pkg::ADDR_STAT, 32'h80);
		results();
	end
endmodule
